/* hdl/csr_special_regs.sv */
`timescale 1ns/10ps
//Operation
// - stack pointer loads 0x07 on reset, the top byte of the lowest bank.
// - on push, increment stack pointer first, then write byte there.
// - high and low pointer bytes join into one 16-bit pointer.
// - combined pointer addresses indirect external data and program flash.
// - carry flag set on add carry or subtract borrow, else cleared.
// - half-carry set on nibble carry or borrow, else cleared.
// - two bank bits choose one of four eight-byte register banks.
// - overflow flag set on signed overflow of add, addc, subb.
// - overflow flag set when multiply product exceeds 255.
// - overflow flag set when divide has a zero divisor.
// - add, addc, subb, mul, div clear overflow otherwise.
// - read-only parity bit is one for odd ones in accumulator.
// - user flags hold software values, untouched by instructions.
// - accumulator at 0xE0, arithmetic target, software readable and writable.
// - second register at 0xF0 assists multiply and divide.
module csr_special_regs #(
   parameter logic [7:0] PTR_LOW_ADDR = csr_pkg::PTR_LOW_ADDR_DEF
) (
   input  wire logic            sys_clk_i,
   input  wire logic            rst_n_i,
   input  wire logic [7:0]      sfr_addr_i,
   input  wire logic            sfr_wr_i,
   input  wire logic [7:0]      sfr_wdata_i,
   input  wire logic            sfr_rd_i,
   output logic [7:0]           sfr_rdata_o,
   output logic                 sfr_hit_o,
   input  wire logic            ex_valid_i,
   input  wire csr_pkg::csr_op_t ex_op_i,
   input  wire logic [7:0]      ex_operand_i,
   input  wire logic            push_i,
   input  wire logic [7:0]      push_data_i,
   input  wire logic            pop_i,
   input  wire logic            data_pointer_pair_inc_i,
   output logic                 stack_wr_o,
   output logic                 stack_rd_o,
   output logic [7:0]           stack_addr_o,
   output logic [7:0]           stack_data_o,
   output logic [7:0]           stack_pointer_o,
   output logic [15:0]          data_pointer_pair_o,
   output logic [7:0]           main_arith_reg_o,
   output logic [7:0]           second_arith_reg_o,
   output logic [7:0]           program_status_word_o,
   output logic [4:0]           bank_base_o
);
   import csr_pkg::*;

   generate
      if (PTR_LOW_ADDR == STACK_ADDR || PTR_LOW_ADDR == PTR_HIGH_ADDR || PTR_LOW_ADDR == STATUS_ADDR ||
          PTR_LOW_ADDR == MAIN_ADDR || PTR_LOW_ADDR == SEC_ADDR) begin : g_bad_addr
         $error("low pointer address collides with another register");
      end
   endgenerate

   logic [7:0] stack_pointer;
   logic [7:0] data_pointer_low;
   logic [7:0] data_pointer_high;
   logic [7:0] main_arith_reg;
   logic [7:0] second_arith_reg;
   logic       carry_flag;
   logic       half_carry_flag;
   logic       user_flag_zero;
   logic       bank_select_high;
   logic       bank_select_low;
   logic       arith_range_flag;
   logic       user_flag_one;
   logic       parity_flag;
   logic [7:0] next_main;
   logic       next_parity;
   logic       sel_stack;
   logic       sel_ptr_low;
   logic       sel_ptr_high;
   logic       sel_status;
   logic       sel_main;
   logic       sel_sec;
   logic       ex_arith;
   logic       ex_wide;
   logic [15:0] data_pointer_pair;

   csr_arith_if arith ();

   // address decode
   always_comb begin
      sel_stack    = 1'b0;
      sel_ptr_low  = 1'b0;
      sel_ptr_high = 1'b0;
      sel_status   = 1'b0;
      sel_main     = 1'b0;
      sel_sec      = 1'b0;
      if (sfr_addr_i == STACK_ADDR) begin
         sel_stack = 1'b1;
      end else if (sfr_addr_i == PTR_LOW_ADDR) begin
         sel_ptr_low = 1'b1;
      end else if (sfr_addr_i == PTR_HIGH_ADDR) begin
         sel_ptr_high = 1'b1;
      end else if (sfr_addr_i == STATUS_ADDR) begin
         sel_status = 1'b1;
      end else if (sfr_addr_i == MAIN_ADDR) begin
         sel_main = 1'b1;
      end else if (sfr_addr_i == SEC_ADDR) begin
         sel_sec = 1'b1;
      end
   end

   assign ex_arith = ex_valid_i && (ex_op_i != CSR_OP_NONE);
   assign ex_wide  = ex_valid_i && (ex_op_i == CSR_OP_MUL || ex_op_i == CSR_OP_DIV);

   assign arith.op       = ex_valid_i ? ex_op_i : CSR_OP_NONE;
   assign arith.lhs      = main_arith_reg;
   assign arith.rhs      = ex_wide ? second_arith_reg : ex_operand_i;
   assign arith.carry_in = carry_flag;

   csr_arith_unit u_arith (
      .arith (arith)
   );

   always_comb begin
      next_main = main_arith_reg;
      if (ex_arith) begin
         next_main = arith.res_lo;
      end else if (sfr_wr_i && sel_main) begin
         next_main = sfr_wdata_i;
      end
   end

   csr_parity #(
      .WIDTH (8)
   ) u_parity (
      .data_i (next_main),
      .odd_o  (next_parity)
   );

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_arith_reg <= MAIN_RESET;
         parity_flag    <= 1'b0;
      end else begin
         main_arith_reg <= next_main;
         parity_flag    <= next_parity;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         second_arith_reg <= SEC_RESET;
      end else if (ex_wide) begin
         second_arith_reg <= arith.res_hi;
      end else if (sfr_wr_i && sel_sec) begin
         second_arith_reg <= sfr_wdata_i;
      end
   end

   // arithmetic flags, instruction wins over software
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         carry_flag       <= STATUS_RESET[CARRY_BIT];
         half_carry_flag  <= STATUS_RESET[HALF_BIT];
         arith_range_flag <= STATUS_RESET[RANGE_BIT];
      end else if (ex_arith) begin
         carry_flag       <= arith.carry;
         half_carry_flag  <= arith.half;
         arith_range_flag <= arith.range;
      end else if (sfr_wr_i && sel_status) begin
         carry_flag       <= sfr_wdata_i[CARRY_BIT];
         half_carry_flag  <= sfr_wdata_i[HALF_BIT];
         arith_range_flag <= sfr_wdata_i[RANGE_BIT];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         user_flag_zero   <= STATUS_RESET[USER0_BIT];
         user_flag_one    <= STATUS_RESET[USER1_BIT];
         bank_select_high <= STATUS_RESET[RSH_BIT];
         bank_select_low  <= STATUS_RESET[RSL_BIT];
         bank_base_o      <= BANK_RESET;
      end else if (sfr_wr_i && sel_status) begin
         user_flag_zero   <= sfr_wdata_i[USER0_BIT];
         user_flag_one    <= sfr_wdata_i[USER1_BIT];
         bank_select_high <= sfr_wdata_i[RSH_BIT];
         bank_select_low  <= sfr_wdata_i[RSL_BIT];
         bank_base_o      <= {sfr_wdata_i[RSH_BIT], sfr_wdata_i[RSL_BIT], BANK_LOW_ZERO};
      end
   end

   // stack pointer and stack strobes
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stack_pointer <= STACK_RESET;
         stack_wr_o    <= 1'b0;
         stack_rd_o    <= 1'b0;
         stack_addr_o  <= STACK_RESET;
         stack_data_o  <= READ_ZERO;
      end else begin
         stack_wr_o <= 1'b0;
         stack_rd_o <= 1'b0;
         if (push_i && !pop_i) begin
            stack_pointer <= stack_pointer + STACK_STEP;
            stack_addr_o  <= stack_pointer + STACK_STEP;
            stack_data_o  <= push_data_i;
            stack_wr_o    <= 1'b1;
         end else if (pop_i && !push_i) begin
            stack_addr_o  <= stack_pointer;
            stack_rd_o    <= 1'b1;
            stack_pointer <= stack_pointer - STACK_STEP;
         end else if (sfr_wr_i && sel_stack) begin
            stack_pointer <= sfr_wdata_i;
         end
      end
   end

   assign data_pointer_pair = {data_pointer_high, data_pointer_low};

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_pointer_low  <= DP_RESET;
         data_pointer_high <= DP_RESET;
      end else if (data_pointer_pair_inc_i) begin
         {data_pointer_high, data_pointer_low} <= data_pointer_pair + PAIR_STEP;
      end else begin
         if (sfr_wr_i && sel_ptr_low) begin
            data_pointer_low <= sfr_wdata_i;
         end
         if (sfr_wr_i && sel_ptr_high) begin
            data_pointer_high <= sfr_wdata_i;
         end
      end
   end

   // registered read port
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sfr_rdata_o <= READ_ZERO;
         sfr_hit_o   <= 1'b0;
      end else begin
         sfr_rdata_o <= READ_ZERO;
         sfr_hit_o   <= 1'b0;
         if (sfr_rd_i) begin
            sfr_hit_o <= 1'b1;
            if (sel_stack) begin
               sfr_rdata_o <= stack_pointer;
            end else if (sel_ptr_low) begin
               sfr_rdata_o <= data_pointer_low;
            end else if (sel_ptr_high) begin
               sfr_rdata_o <= data_pointer_high;
            end else if (sel_status) begin
               sfr_rdata_o <= program_status_word_o;
            end else if (sel_main) begin
               sfr_rdata_o <= main_arith_reg;
            end else if (sel_sec) begin
               sfr_rdata_o <= second_arith_reg;
            end else begin
               sfr_hit_o <= 1'b0;
            end
         end
      end
   end

   assign stack_pointer_o    = stack_pointer;
   assign data_pointer_pair_o = data_pointer_pair;
   assign main_arith_reg_o    = main_arith_reg;
   assign second_arith_reg_o  = second_arith_reg;
   assign program_status_word_o = {carry_flag, half_carry_flag, user_flag_zero, bank_select_high,
                                   bank_select_low, arith_range_flag, user_flag_one, parity_flag};

   // checking helpers
   logic [8:0] ref_sum9;
   logic [4:0] ref_nib5;
   logic [15:0] ref_prod;
   assign ref_sum9 = {1'b0, main_arith_reg} + {1'b0, ex_operand_i};
   assign ref_nib5 = {1'b0, main_arith_reg[3:0]} + {1'b0, ex_operand_i[3:0]};
   assign ref_prod = {8'h00, main_arith_reg} * {8'h00, second_arith_reg};

   chk_sp_reset: assert property (@(posedge sys_clk_i) $rose(rst_n_i) |-> stack_pointer_o == STACK_RESET)
      else $error("stack pointer not at reset value after reset");

   chk_push_order: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      push_i && !pop_i |=> stack_wr_o && stack_addr_o == $past(stack_pointer_o) + STACK_STEP
                           && stack_pointer_o == stack_addr_o)
      else $error("push did not pre-increment stack pointer");

   chk_pair_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      sfr_wr_i && sel_ptr_high && !data_pointer_pair_inc_i |=> data_pointer_pair_o[15:8] == $past(sfr_wdata_i))
      else $error("high pointer byte not in upper half");

   chk_add_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ex_valid_i && ex_op_i == CSR_OP_ADD |=> program_status_word_o[CARRY_BIT] == $past(ref_sum9[8]))
      else $error("carry flag wrong after add");

   chk_add_half: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ex_valid_i && ex_op_i == CSR_OP_ADD |=> program_status_word_o[HALF_BIT] == $past(ref_nib5[4]))
      else $error("half carry wrong after add");

   chk_bank_base: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      bank_base_o == {program_status_word_o[RSH_BIT], program_status_word_o[RSL_BIT], BANK_LOW_ZERO})
      else $error("bank base does not follow bank bits");

   chk_mul_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ex_valid_i && ex_op_i == CSR_OP_MUL |=> arith_range_flag == ($past(ref_prod[15:8]) != 8'h00)
                                             && main_arith_reg_o == $past(ref_prod[7:0]))
      else $error("multiply overflow or product wrong");

   chk_div_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ex_valid_i && ex_op_i == CSR_OP_DIV && second_arith_reg == 8'h00 |=> arith_range_flag)
      else $error("divide by zero did not set overflow");

   chk_parity_track: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $changed(main_arith_reg_o) |-> program_status_word_o[PAR_BIT] == ^main_arith_reg_o)
      else $error("parity does not match accumulator");

   chk_user_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !(sfr_wr_i && sel_status) |=> $stable(user_flag_zero) && $stable(user_flag_one))
      else $error("user flag changed without software write");

   chk_psw_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      sfr_wr_i && sel_status && !ex_arith |=> program_status_word_o[7:1] == $past(sfr_wdata_i[7:1]))
      else $error("status write did not update writable bits");

endmodule // csr_special_regs

/* hdl/csr_pkg.sv */
package csr_pkg;

   // special-function addresses
   localparam logic [7:0] STACK_ADDR       = 8'h81;
   localparam logic [7:0] PTR_LOW_ADDR_DEF = 8'h82;
   localparam logic [7:0] PTR_HIGH_ADDR    = 8'h83;
   localparam logic [7:0] STATUS_ADDR      = 8'hd0;
   localparam logic [7:0] MAIN_ADDR        = 8'he0;
   localparam logic [7:0] SEC_ADDR         = 8'hf0;

   // reset values
   localparam logic [7:0] STACK_RESET  = 8'h07;
   localparam logic [7:0] DP_RESET     = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MAIN_RESET   = 8'h00;
   localparam logic [7:0] SEC_RESET    = 8'h00;
   localparam logic [7:0] READ_ZERO    = 8'h00;

   // status word bit positions
   localparam int CARRY_BIT = 7;
   localparam int HALF_BIT  = 6;
   localparam int USER0_BIT = 5;
   localparam int RSH_BIT   = 4;
   localparam int RSL_BIT   = 3;
   localparam int RANGE_BIT = 2;
   localparam int USER1_BIT = 1;
   localparam int PAR_BIT   = 0;

   // pointer steps and bank base layout
   localparam logic [7:0]  STACK_STEP    = 8'h01;
   localparam logic [15:0] PAIR_STEP     = 16'h0001;
   localparam logic [2:0]  BANK_LOW_ZERO = 3'h0;
   localparam logic [4:0]  BANK_RESET    = 5'h00;

   typedef enum logic [2:0] {
      CSR_OP_NONE = 3'b000,
      CSR_OP_ADD  = 3'b001,
      CSR_OP_ADDC = 3'b010,
      CSR_OP_SUBB = 3'b011,
      CSR_OP_MUL  = 3'b100,
      CSR_OP_DIV  = 3'b101
   } csr_op_t;

endpackage

/* hdl/csr_arith_if.sv */
`timescale 1ns/10ps
interface csr_arith_if;
   import csr_pkg::*;
   csr_op_t    op;
   logic [7:0] lhs;
   logic [7:0] rhs;
   logic       carry_in;
   logic [7:0] res_lo;
   logic [7:0] res_hi;
   logic       carry;
   logic       half;
   logic       range;

   modport core (output op, lhs, rhs, carry_in, input res_lo, res_hi, carry, half, range);
   modport unit (input op, lhs, rhs, carry_in, output res_lo, res_hi, carry, half, range);
endinterface

/* hdl/csr_parity.sv */
`timescale 1ns/10ps
module csr_parity #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] data_i,
   output logic                  odd_o
);
   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("parity width must be at least one");
      end
   endgenerate

   // odd count of ones gives one
   assign odd_o = ^data_i;
endmodule // csr_parity

/* hdl/csr_arith_unit.sv */
`timescale 1ns/10ps
module csr_arith_unit (
   csr_arith_if.unit arith
);
   import csr_pkg::*;

   logic        eff_cin;
   logic [8:0]  sum9;
   logic [4:0]  nib5;
   logic [8:0]  diff9;
   logic [4:0]  nibd;
   logic [15:0] prod;

   always_comb begin
      eff_cin = (arith.op == CSR_OP_ADDC || arith.op == CSR_OP_SUBB) ? arith.carry_in : 1'b0;
      sum9  = {1'b0, arith.lhs} + {1'b0, arith.rhs} + {8'h00, eff_cin};
      nib5  = {1'b0, arith.lhs[3:0]} + {1'b0, arith.rhs[3:0]} + {4'h0, eff_cin};
      diff9 = {1'b0, arith.lhs} - {1'b0, arith.rhs} - {8'h00, eff_cin};
      nibd  = {1'b0, arith.lhs[3:0]} - {1'b0, arith.rhs[3:0]} - {4'h0, eff_cin};
      prod  = {8'h00, arith.lhs} * {8'h00, arith.rhs};
   end

   always_comb begin
      arith.res_lo = arith.lhs;
      arith.res_hi = arith.rhs;
      arith.carry  = 1'b0;
      arith.half   = 1'b0;
      arith.range  = 1'b0;
      case (arith.op)
         CSR_OP_ADD, CSR_OP_ADDC: begin
            arith.res_lo = sum9[7:0];
            arith.carry  = sum9[8];
            arith.half   = nib5[4];
            arith.range  = (arith.lhs[7] == arith.rhs[7]) && (sum9[7] != arith.lhs[7]);
         end
         CSR_OP_SUBB: begin
            arith.res_lo = diff9[7:0];
            arith.carry  = diff9[8];
            arith.half   = nibd[4];
            arith.range  = (arith.lhs[7] != arith.rhs[7]) && (diff9[7] != arith.lhs[7]);
         end
         CSR_OP_MUL: begin
            arith.res_lo = prod[7:0];
            arith.res_hi = prod[15:8];
            arith.range  = (prod[15:8] != 8'h00);
         end
         CSR_OP_DIV: begin
            if (arith.rhs == 8'h00) begin
               arith.range = 1'b1;
            end else begin
               arith.res_lo = arith.lhs / arith.rhs;
               arith.res_hi = arith.lhs % arith.rhs;
            end
         end
         default: begin
            arith.res_lo = arith.lhs;
         end
      endcase
   end
endmodule // csr_arith_unit

/* bench/csr_stack_mem.sv */
`timescale 1ns/10ps
// stack memory beside the core, filled by push strobes
module csr_stack_mem (
   input  wire logic       sys_clk_i,
   input  wire logic       stack_wr_i,
   input  wire logic       stack_rd_i,
   input  wire logic [7:0] stack_addr_i,
   input  wire logic [7:0] stack_data_i,
   output logic [7:0]      rdata_o
);
   logic [7:0] mem [256];

   // byte lands at the bumped pointer
   always_ff @(posedge sys_clk_i) begin
      if (stack_wr_i) begin
         mem[stack_addr_i] <= stack_data_i;
      end
   end

   // released data line shows inverse when idle
   assign rdata_o = stack_rd_i ? mem[stack_addr_i] : ~mem[stack_addr_i];
endmodule // csr_stack_mem

/* bench/core_special_registers_tb.sv */
`timescale 1ns/10ps
module core_special_registers_tb;
   import csr_pkg::*;
   localparam logic [7:0] a_stack    = 8'h81;
   localparam logic [7:0] a_ptr_lo   = 8'h82;
   localparam logic [7:0] a_ptr_hi   = 8'h83;
   localparam logic [7:0] a_status   = 8'hd0;
   localparam logic [7:0] a_main     = 8'he0;
   localparam logic [7:0] a_second   = 8'hf0;
   localparam logic [7:0] a_unmapped = 8'h87;
   localparam int         timeout_cycles = 2000;

   logic        sys_clk_i, rst_n_i, sfr_wr, sfr_rd, ex_valid, push, pop, data_pointer_pair_inc;
   logic [7:0]  sfr_addr, sfr_wdata, ex_operand, push_data;
   csr_op_t     ex_op;
   logic [7:0]  sfr_rdata, stack_addr, stack_data, stack_q, main_q, second_q, status_q, mem_rdata;
   logic        sfr_hit, stack_wr, stack_rd;
   logic [15:0] pair_q;
   logic [4:0]  bank_base;
   int          errors, check_count, cycles;

   csr_special_regs DUT (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr),
      .sfr_wdata_i(sfr_wdata), .sfr_rd_i(sfr_rd), .sfr_rdata_o(sfr_rdata), .sfr_hit_o(sfr_hit),
      .ex_valid_i(ex_valid), .ex_op_i(ex_op), .ex_operand_i(ex_operand), .push_i(push),
      .push_data_i(push_data), .pop_i(pop), .data_pointer_pair_inc_i(data_pointer_pair_inc), .stack_wr_o(stack_wr),
      .stack_rd_o(stack_rd), .stack_addr_o(stack_addr), .stack_data_o(stack_data),
      .stack_pointer_o(stack_q), .data_pointer_pair_o(pair_q), .main_arith_reg_o(main_q),
      .second_arith_reg_o(second_q), .program_status_word_o(status_q), .bank_base_o(bank_base)
   );

   csr_stack_mem stack_model (
      .sys_clk_i(sys_clk_i), .stack_wr_i(stack_wr), .stack_rd_i(stack_rd),
      .stack_addr_i(stack_addr), .stack_data_i(stack_data), .rdata_o(mem_rdata)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk_i) begin
      cycles = cycles + 1;
      if (cycles >= timeout_cycles) begin
         errors = errors + 1;
         give_verdict();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expected);
      check_count = check_count + 1;
      if (seen !== expected) begin
         errors = errors + 1;
         $display("BAD %s expected %h seen %h", name, expected, seen);
      end
   endtask

   task automatic tick();
      @(posedge sys_clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      sfr_addr = addr;
      sfr_wdata = data;
      sfr_wr = 1'b1;
      tick();
      sfr_wr = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [7:0] addr, input logic [7:0] expected, input logic hit);
      sfr_addr = addr;
      sfr_rd = 1'b1;
      tick();
      sfr_rd = 1'b0;
      check("read data", {8'h00, sfr_rdata}, {8'h00, expected});
      check("read hit", {15'h0000, sfr_hit}, {15'h0000, hit});
      tick();
   endtask

   task automatic ex(input csr_op_t op, input logic [7:0] operand, input logic [7:0] exp_main,
                     input logic [7:0] exp_status);
      ex_valid = 1'b1;
      ex_op = op;
      ex_operand = operand;
      tick();
      ex_valid = 1'b0;
      check("main after op", {8'h00, main_q}, {8'h00, exp_main});
      check("status after op", {8'h00, status_q}, {8'h00, exp_status});
      tick();
   endtask

   task automatic test_reset_values();
      wr(a_unmapped, 8'hff);
      rd(a_stack, 8'h07, 1'b1);
      rd(a_ptr_hi, 8'h00, 1'b1);
      rd(a_ptr_lo, 8'h00, 1'b1);
      rd(a_status, 8'h00, 1'b1);
      rd(a_main, 8'h00, 1'b1);
      rd(a_second, 8'h00, 1'b1);
      rd(a_unmapped, 8'h00, 1'b0);
      check("stack pointer", {8'h00, stack_q}, 16'h0007);
   endtask

   task automatic push_byte(input logic [7:0] data, input logic [7:0] exp_addr);
      push = 1'b1;
      push_data = data;
      tick();
      push = 1'b0;
      check("push strobe", {15'h0000, stack_wr}, 16'h0001);
      check("push addr", {8'h00, stack_addr}, {8'h00, exp_addr});
      check("push data", {8'h00, stack_data}, {8'h00, data});
      check("stack after push", {8'h00, stack_q}, {8'h00, exp_addr});
      tick();
   endtask

   task automatic test_stack();
      push_byte(8'haa, 8'h08);
      push_byte(8'h55, 8'h09);
      pop = 1'b1;
      tick();
      check("pop strobe", {15'h0000, stack_rd}, 16'h0001);
      check("pop addr", {8'h00, stack_addr}, 16'h0009);
      check("popped byte", {8'h00, mem_rdata}, 16'h0055);
      check("stack after pop", {8'h00, stack_q}, 16'h0008);
      push = 1'b1;
      tick();
      push = 1'b0;
      pop = 1'b0;
      check("both strobes idle", {14'h0000, stack_wr, stack_rd}, 16'h0000);
      rd(a_stack, 8'h08, 1'b1);
      wr(a_stack, 8'hfe);
      push_byte(8'h3c, 8'hff);
   endtask

   task automatic test_pointer();
      wr(a_ptr_hi, 8'h12);
      wr(a_ptr_lo, 8'h34);
      check("pointer pair", pair_q, 16'h1234);
      data_pointer_pair_inc = 1'b1;
      tick();
      data_pointer_pair_inc = 1'b0;
      check("pointer step", pair_q, 16'h1235);
      wr(a_ptr_hi, 8'hff);
      wr(a_ptr_lo, 8'hff);
      data_pointer_pair_inc = 1'b1;
      tick();
      data_pointer_pair_inc = 1'b0;
      check("pointer wrap", pair_q, 16'h0000);
      rd(a_ptr_hi, 8'h00, 1'b1);
   endtask

   task automatic test_banks();
      for (int code = 0; code < 4; code++) begin
         wr(a_status, 8'(code << 3));
         check("bank base", {11'h000, bank_base}, 16'(code * 8));
      end
      wr(a_status, 8'hff);
      rd(a_status, 8'hfe, 1'b1);
   endtask

   task automatic test_arith();
      wr(a_main, 8'hff);
      wr(a_status, 8'h22);
      ex(CSR_OP_ADD, 8'h01, 8'h00, 8'he2);
      wr(a_main, 8'h7f);
      ex(CSR_OP_ADD, 8'h01, 8'h80, 8'h67);
      ex(CSR_OP_ADDC, 8'h80, 8'h00, 8'ha6);
      ex(CSR_OP_ADDC, 8'h00, 8'h01, 8'h23);
      ex(CSR_OP_SUBB, 8'h02, 8'hff, 8'he2);
      ex(CSR_OP_SUBB, 8'h7f, 8'h7f, 8'h67);
      wr(a_second, 8'h03);
      ex(CSR_OP_MUL, 8'h00, 8'h7d, 8'h26);
      check("second after mul", {8'h00, second_q}, 16'h0001);
      ex(CSR_OP_MUL, 8'h00, 8'h7d, 8'h22);
      ex(CSR_OP_DIV, 8'h00, 8'h7d, 8'h26);
      wr(a_second, 8'h0a);
      ex(CSR_OP_DIV, 8'h00, 8'h0c, 8'h22);
      rd(a_second, 8'h05, 1'b1);
      rd(a_main, 8'h0c, 1'b1);
   endtask

   initial begin
      errors = 0;
      check_count = 0;
      cycles = 0;
      rst_n_i = 1'b0;
      {sfr_wr, sfr_rd, ex_valid, push, pop, data_pointer_pair_inc} = 6'h00;
      {sfr_addr, sfr_wdata, ex_operand, push_data} = 32'h0000_0000;
      ex_op = CSR_OP_NONE;
      repeat (5) @(posedge sys_clk_i);
      #1;
      rst_n_i = 1'b1;
      tick();
      test_reset_values();
      test_stack();
      test_pointer();
      test_banks();
      test_arith();
      give_verdict();
   end
endmodule // core_special_registers_tb
